// ===== core/bdr_pkg.sv
// constants and carrier types for the background debug register bank
package bdr_pkg;

    // ========================================================
    // register addresses
    localparam logic [15:0] ADDR_STATUS     = 16'hff01;
    localparam logic [15:0] ADDR_CCR_HOLD   = 16'hff06;
    localparam logic [15:0] ADDR_BASE_SHDW  = 16'hff07;
    localparam logic [15:0] ADDR_WIN_FIRST  = 16'hff00;
    localparam logic [15:0] ADDR_WIN_LAST   = 16'hff0b;

    // ========================================================
    // status field positions
    localparam int BIT_ENABLE  = 7;
    localparam int BIT_ACTIVE  = 6;
    localparam int BIT_TAGGING = 5;
    localparam int BIT_SHIFT   = 4;
    localparam int BIT_TRACE   = 3;
    localparam int BIT_CLKSEL  = 2;
    localparam int BIT_UNSECURE_FLAG   = 1;

    // shadow layout: bits 6..3 carry base bits 14..11
    localparam int SHDW_LO   = 3;
    localparam int SHDW_HI   = 6;
    localparam int BASE_LO   = 11;
    localparam int BASE_HI   = 14;

    // ========================================================
    // reset values and reserved read value
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [7:0] CCR_RESET      = 8'hd0;
    localparam logic [7:0] CCR_SPECIAL    = 8'hd8;
    localparam logic [7:0] READ_RESERVED  = 8'h00;

    // ========================================================
    // timing
    localparam int CLK_MHZ          = 100;
    localparam int TAG_DELAY_CYC    = 16;
    localparam int CLOCK_SELECT_BIT_SETTLE_CYC = 150;
    localparam logic [7:0] TAG_DELAY_CNT    = 8'(TAG_DELAY_CYC);
    localparam logic [7:0] CLOCK_SELECT_BIT_SETTLE_CNT = 8'(CLOCK_SELECT_BIT_SETTLE_CYC);

    // firmware command classes seen by the status logic
    typedef enum logic [1:0] {
        BDR_CMD_OTHER = 2'b00,
        BDR_CMD_TRACE = 2'b01,
        BDR_CMD_TAG_AND_GO_CMD = 2'b10
    } bdr_cmd_t;

    // register access request from serial engine
    typedef struct packed {
        logic        rd;        // debug_read_cmd
        logic        wr;        // debug_write_cmd
        logic        fw;        // access from standard firmware write
        logic        secure_fw; // access from secure firmware
        logic [15:0] addr;
        logic [7:0]  wdata;
    } bdr_req_t;

    // events reported by serial engine and core
    typedef struct packed {
        logic     cmd_recv;     // a new command was received
        bdr_cmd_t cmd_kind;     // class of recognised command
        logic     data_done;    // firmware data phase complete
        logic     enter;        // request entry to active debug
        logic     exit_store;   // firmware exit store
        logic     secure_enter; // part entered secure mode
    } bdr_evt_t;

endpackage

// ===== core/bdr_sync2.sv
// two-flop synchroniser for one pin level
`timescale 1ns/100ps
module bdr_sync2 (
    input  wire logic core_clk,   // clock
    input  wire logic reset_n,    // sync reset, low
    input  wire logic d,          // async level
    output logic      q           // synchronised level
);
    logic meta;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            meta <= 1'b1;
            q    <= 1'b1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ===== core/bdr_delay.sv
// down-counter that pulses done after a loaded number of cycles
`timescale 1ns/100ps
module bdr_delay (
    input  wire logic       core_clk, // clock
    input  wire logic       reset_n,  // sync reset, low
    input  wire logic       start,    // load count
    input  wire logic [7:0] count,    // cycles to wait
    output logic            busy,     // counting
    output logic            done      // one-cycle pulse at end
);
    logic [7:0] remain;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            remain <= 8'h00;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else if (start) begin
            remain <= count - 8'h01;
            busy   <= 1'b1;
            done   <= 1'b0;
        end else if (busy && remain == 8'h00) begin
            busy   <= 1'b0;
            done   <= 1'b1;
        end else begin
            remain <= busy ? remain - 8'h01 : remain;
            done   <= 1'b0;
        end
    end
endmodule

// ===== core/bdr_regs.sv
// background debug register bank, pin sampling and tagging
// Operation
// - during reset sample debug pin as mode select; afterwards only serial use
// - tagging on: high tag pin low at bus clock fall marks upper half
// - tagging plus low strobe: low tag pin low marks lower half
// - registers reached by host debug read and write commands and by standard firmware writes
// - status register at ff01, bit 0 reads zero, neighbours reserved
// - condition-code holding register at ff06, read and write
// - read-only shadow at ff07, bits 6..3 show base bits 14..11
// - enable bit gates entry to active debug; hardware commands still run
// - special single-chip: firmware sets enable; secured waits for erase checks
// - active bit set by hardware on entry, cleared only by exit store
// - tag-and-go sets tagging bit; 17 cycles later serial off, tagging on
// - shift valid set after firmware data phase, cleared next command or exit
// - trace bit set on first trace, held across traces, cleared otherwise
// - clock-select writable only by hardware or standard firmware writes
// - special single-chip: unsecure flag reads 1 if secured and erased
// - special single-chip: enable reads 1 once firmware sets it while unsecured or after erase checks finish
// - alternate clock only when clock-select 0 and pll-select 1
// - new clock guaranteed after 150 cycles; next command uses it
// - unsecure flag writable only by secure firmware in special single-chip; zero on secure entry
`timescale 1ns/100ps
module bdr_regs (
    input  wire logic              core_clk,         // bus clock
    input  wire logic              reset_n,          // sync reset, low
    input  wire logic              debug_wire_pin,   // single-wire pin level
    output logic                   debug_wire_out,   // pin drive value
    output logic                   debug_wire_oe_n,  // pin drive enable, low
    output logic                   special_mode,     // mode captured at reset
    output logic                   serial_enable,    // serial engine may run
    input  wire logic              high_tag_pin,     // high tag strobe pin
    input  wire logic              low_tag_pin,      // low tag strobe pin
    input  wire logic              low_strobe_en,    // low strobe enabled
    input  wire logic              external_bus_clock, // external bus clock pin
    output logic                   tag_high,         // upper half tagged
    output logic                   tag_low,          // lower half tagged
    input  wire bdr_pkg::bdr_req_t req,              // register access
    output logic [7:0]             rdata,            // read data
    output logic                   rvalid,           // read data valid
    input  wire bdr_pkg::bdr_evt_t evt,              // command events
    input  wire logic              fw_set_enable,    // firmware sets enable
    input  wire logic              secured,          // part is secured
    input  wire logic              erased,           // erase checks passed
    input  wire logic              erase_done,       // erase checks finished
    input  wire logic [15:0]       reg_base,         // register block base
    input  wire logic              pll_select_signal,// pll select level
    output logic                   debug_active,     // active debug mode
    output logic                   fw_table_mapped,  // firmware table in map
    output logic                   use_alt_clock,    // debug clock selection
    output logic                   clock_settling,   // clock switch settling
    output logic [7:0]             status_view       // status register view
);
    // ========================================================
    // pin synchronisers
    logic pin_s;
    logic htag_s;
    logic ltag_s;
    logic external_bus_clock_s;

    // the mode pin chain runs through reset: the strap level must reach
    // the capture flop while reset is still held
    bdr_sync2 u_sync_pin (
        .core_clk (core_clk),
        .reset_n  (1'b1),
        .d        (debug_wire_pin),
        .q        (pin_s)
    );
    bdr_sync2 u_sync_htag (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .d        (high_tag_pin),
        .q        (htag_s)
    );
    bdr_sync2 u_sync_ltag (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .d        (low_tag_pin),
        .q        (ltag_s)
    );
    bdr_sync2 u_sync_external_bus_clock (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .d        (external_bus_clock),
        .q        (external_bus_clock_s)
    );

    // ========================================================
    // mode capture
    // level is tracked while reset is held and frozen on release,
    // so serial traffic on the pin afterwards cannot change the mode
    logic mode_taken;
    logic pin_in_reset;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pin_in_reset <= 1'b1;
        end else if (!mode_taken) begin
            pin_in_reset <= pin_s;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mode_taken   <= 1'b0;
            special_mode <= ~pin_s;
        end else if (!mode_taken) begin
            mode_taken   <= 1'b1;
        end
    end

    // pin is released here; serial driving belongs to the engine
    assign debug_wire_out  = 1'b0;
    assign debug_wire_oe_n = 1'b1;

    // ========================================================
    // status bits
    logic en_bit;
    logic act_bit;
    logic tag_bit;
    logic sdv_bit;
    logic trc_bit;
    logic clk_bit;
    logic uns_bit;
    logic [7:0] ccr_hold;

    logic wr_status;
    logic wr_ccr;
    logic hw_or_fw;

    assign hw_or_fw  = req.wr || req.fw;
    assign wr_status = hw_or_fw && req.addr == bdr_pkg::ADDR_STATUS;
    assign wr_ccr    = hw_or_fw && req.addr == bdr_pkg::ADDR_CCR_HOLD;

    logic do_enter;
    assign do_enter = evt.enter && en_bit;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            en_bit <= bdr_pkg::STATUS_RESET[bdr_pkg::BIT_ENABLE];
        end else if (special_mode && fw_set_enable && (!secured || erase_done)) begin
            en_bit <= 1'b1;
        end else if (wr_status) begin
            en_bit <= req.wdata[bdr_pkg::BIT_ENABLE];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            act_bit <= bdr_pkg::STATUS_RESET[bdr_pkg::BIT_ACTIVE];
        end else if (do_enter) begin
            act_bit <= 1'b1;
        end else if (evt.exit_store) begin
            act_bit <= 1'b0;
        end
    end

    // tagging: set by tag-and-go, cleared on entry
    logic tag_start;
    logic tag_busy;
    logic tag_done;
    logic tag_live;

    assign tag_start = evt.cmd_recv && evt.cmd_kind == bdr_pkg::BDR_CMD_TAG_AND_GO_CMD && !tag_live;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tag_bit <= bdr_pkg::STATUS_RESET[bdr_pkg::BIT_TAGGING];
        end else if (do_enter) begin
            tag_bit <= 1'b0;
        end else if (tag_start) begin
            tag_bit <= 1'b1;
        end else if (wr_status) begin
            tag_bit <= req.wdata[bdr_pkg::BIT_TAGGING];
        end
    end

    bdr_delay u_tag_delay (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .start    (tag_start),
        .count    (bdr_pkg::TAG_DELAY_CNT),
        .busy     (tag_busy),
        .done     (tag_done)
    );

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            tag_live <= 1'b0;
        end else if (do_enter || !tag_bit) begin
            tag_live <= 1'b0;
        end else if (tag_done) begin
            tag_live <= 1'b1;
        end
    end

    // no serial commands while tagging is live
    assign serial_enable = !tag_live;

    // shift valid: data phase wins over a same-cycle new command
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sdv_bit <= bdr_pkg::STATUS_RESET[bdr_pkg::BIT_SHIFT];
        end else if (evt.data_done) begin
            sdv_bit <= 1'b1;
        end else if (evt.cmd_recv || evt.exit_store) begin
            sdv_bit <= 1'b0;
        end else if (wr_status) begin
            sdv_bit <= req.wdata[bdr_pkg::BIT_SHIFT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            trc_bit <= bdr_pkg::STATUS_RESET[bdr_pkg::BIT_TRACE];
        end else if (evt.cmd_recv) begin
            trc_bit <= evt.cmd_kind == bdr_pkg::BDR_CMD_TRACE;
        end else if (wr_status) begin
            trc_bit <= req.wdata[bdr_pkg::BIT_TRACE];
        end
    end

    // ========================================================
    // clock select and settling
    logic clk_change;
    assign clk_change = wr_status && req.wdata[bdr_pkg::BIT_CLKSEL] != clk_bit;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            clk_bit <= bdr_pkg::STATUS_RESET[bdr_pkg::BIT_CLKSEL];
        end else if (wr_status) begin
            clk_bit <= req.wdata[bdr_pkg::BIT_CLKSEL];
        end
    end

    bdr_delay u_clk_delay (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .start    (clk_change),
        .count    (bdr_pkg::CLOCK_SELECT_BIT_SETTLE_CNT),
        .busy     (clock_settling),
        .done     ()
    );

    assign use_alt_clock = !clk_bit && pll_select_signal;

    // ========================================================
    // unsecure flag
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            uns_bit <= bdr_pkg::STATUS_RESET[bdr_pkg::BIT_UNSECURE_FLAG];
        end else if (evt.secure_enter) begin
            uns_bit <= 1'b0;
        end else if (wr_status && req.secure_fw && special_mode) begin
            uns_bit <= req.wdata[bdr_pkg::BIT_UNSECURE_FLAG];
        end
    end

    // ========================================================
    // condition-code holding register
    logic mode_seen;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            mode_seen <= 1'b0;
            ccr_hold  <= bdr_pkg::CCR_RESET;
        end else if (mode_taken && !mode_seen) begin
            mode_seen <= 1'b1;
            ccr_hold  <= special_mode ? bdr_pkg::CCR_SPECIAL : bdr_pkg::CCR_RESET;
        end else if (wr_ccr) begin
            ccr_hold  <= req.wdata;
        end
    end

    // ========================================================
    // read path
    logic [7:0] stat;
    logic [7:0] shdw;
    logic       uns_read;

    assign uns_read = special_mode ? (secured && erased) || uns_bit : uns_bit;

    always_comb begin
        stat = 8'h00;
        stat[bdr_pkg::BIT_ENABLE]  = en_bit;
        stat[bdr_pkg::BIT_ACTIVE]  = act_bit;
        stat[bdr_pkg::BIT_TAGGING] = tag_bit;
        stat[bdr_pkg::BIT_SHIFT]   = sdv_bit;
        stat[bdr_pkg::BIT_TRACE]   = trc_bit;
        stat[bdr_pkg::BIT_CLKSEL]  = clk_bit;
        stat[bdr_pkg::BIT_UNSECURE_FLAG]   = uns_read;
    end

    always_comb begin
        shdw = 8'h00;
        shdw[bdr_pkg::SHDW_HI:bdr_pkg::SHDW_LO] =
            reg_base[bdr_pkg::BASE_HI:bdr_pkg::BASE_LO];
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rdata  <= 8'h00;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd;
            case (req.addr)
                bdr_pkg::ADDR_STATUS:    rdata <= stat;
                bdr_pkg::ADDR_CCR_HOLD:  rdata <= ccr_hold;
                bdr_pkg::ADDR_BASE_SHDW: rdata <= shdw;
                default:                 rdata <= bdr_pkg::READ_RESERVED;
            endcase
        end
    end

    assign status_view     = stat;
    assign debug_active    = act_bit;
    assign fw_table_mapped = act_bit;

    // ========================================================
    // instruction tagging on falling external bus clock
    logic external_bus_clock_d;
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            external_bus_clock_d   <= 1'b0;
            tag_high <= 1'b0;
            tag_low  <= 1'b0;
        end else begin
            external_bus_clock_d <= external_bus_clock_s;
            if (external_bus_clock_d && !external_bus_clock_s && tag_live) begin
                tag_high <= !htag_s;
                tag_low  <= !ltag_s && low_strobe_en;
            end else begin
                tag_high <= 1'b0;
                tag_low  <= 1'b0;
            end
        end
    end

    logic unused_ok;
    assign unused_ok = pin_in_reset ^ tag_busy;
endmodule

// ===== verif/bdr_regs_sva.sv
// assertion checker for the debug register bank
`timescale 1ns/100ps
module bdr_regs_sva (
    input wire logic              core_clk,          // clock
    input wire logic              reset_n,           // sync reset, low
    input wire bdr_pkg::bdr_req_t req,               // register access
    input wire logic [7:0]        rdata,             // read data
    input wire logic              rvalid,            // read valid
    input wire bdr_pkg::bdr_evt_t evt,               // command events
    input wire logic [15:0]       reg_base,          // register base
    input wire logic              pll_select_signal, // pll select
    input wire logic              serial_enable,     // serial allowed
    input wire logic [7:0]        status_view,       // status view
    input wire logic              use_alt_clock      // clock choice
);
    // ==========
    // helpers
    logic [3:0] base_hi;
    logic       is_trace;
    logic       quiet;
    assign base_hi = reg_base[14:11];
    assign is_trace = evt.cmd_kind == bdr_pkg::BDR_CMD_TRACE;
    // same-cycle writes are left out; the event effects already take priority over them
    assign quiet = !req.wr && !req.fw;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    // ==========
    // properties
    property p_bit0; status_view[0] == 1'b0; endproperty
    a_bit0: assert property (p_bit0) else $error("status bit 0 set");
    property p_rd_ans; req.rd |=> rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_shdw; rvalid && $past(req.addr) == bdr_pkg::ADDR_BASE_SHDW
        |-> rdata == {1'b0, $past(base_hi), 3'b000}; endproperty
    a_shdw: assert property (p_shdw) else $error("shadow read wrong");
    property p_alt; use_alt_clock == (!status_view[2] && pll_select_signal); endproperty
    a_alt: assert property (p_alt) else $error("clock choice wrong");
    property p_act_set; $rose(status_view[6]) |-> $past(evt.enter) && $past(status_view[7]);
    endproperty
    a_act_set: assert property (p_act_set) else $error("active set wrongly");
    property p_act_clr; $fell(status_view[6]) |-> $past(evt.exit_store); endproperty
    a_act_clr: assert property (p_act_clr) else $error("active cleared wrongly");
    property p_sdv; evt.data_done && quiet && !evt.exit_store |=> status_view[4]; endproperty
    a_sdv: assert property (p_sdv) else $error("shift valid not set");
    property p_trace; evt.cmd_recv && quiet |=> status_view[3] == $past(is_trace); endproperty
    a_trace: assert property (p_trace) else $error("trace bit wrong");
    property p_tag; $rose(status_view[5]) |-> serial_enable [*8] ##[6:10] !serial_enable;
    endproperty
    a_tag: assert property (p_tag) else $error("tag delay wrong");
endmodule
bind bdr_regs bdr_regs_sva u_chk (
    .core_clk(core_clk), .reset_n(reset_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .evt(evt), .reg_base(reg_base), .pll_select_signal(pll_select_signal),
    .serial_enable(serial_enable), .status_view(status_view),
    .use_alt_clock(use_alt_clock));

// ===== verif/bdr_host.sv
// host debug pod model issuing register accesses
`timescale 1ns/100ps
module bdr_host (
    input  wire logic         core_clk,       // clock
    input  wire logic         reset_n,        // sync reset, low
    input  wire logic         want_special,   // mode asked for at reset
    input  wire logic         dev_out,        // device pin value
    input  wire logic         dev_oe_n,       // device pin enable, low
    output logic              debug_wire_pin, // resolved wire level
    output bdr_pkg::bdr_req_t req             // register access
);
    // ==========
    // wire: pull-up once the pod lets go after reset
    assign debug_wire_pin = !dev_oe_n ? dev_out : (reset_n ? 1'b1 : !want_special);
    initial req = '0;
    // idle cycle first so two strobes never merge
    // a status write loads the enable bit from bit 7 of d unless special-mode firmware sets enable in the same cycle
    task automatic put(input logic wr, input logic fw, input logic sfw,
                       input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1;
        req = '{!wr && !fw, wr, fw, sfw, a, d};
        @(posedge core_clk);
        #1;
        req = '{1'b0, 1'b0, 1'b0, 1'b0, ~a, ~d};
    endtask
endmodule

// ===== verif/testbench.sv
// self-checking bench for the debug register bank
`timescale 1ns/100ps
module testbench;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic ht = 1'b1, lt = 1'b1, lse = 1'b0, ebc = 1'b0;
    logic fse = 1'b0, sec = 1'b0, ers = 1'b0, edn = 1'b0, pll = 1'b0, wsp = 1'b1;
    logic [15:0] base = 16'h0000;
    logic [7:0] d;
    logic [6:0] e;
    bdr_pkg::bdr_evt_t evt = '0;
    bdr_pkg::bdr_req_t req;
    logic pin, pout, poe_n, smode, ser, th, tl, act, alt, settle, rvalid, ftm;
    logic [7:0] rdata, sv;
    logic [15:0] rsv [6] = '{16'hff00, 16'hff02, 16'hff05, 16'hff08, 16'hff0b, 16'hff0c};
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    int m_en = 0, m_act = 0, m_tag = 0, m_sdv = 0, m_trc = 0, m_clk = 0, m_uns = 0;
    int nh, nl, n;

    bdr_host u_bdr_host (.core_clk(core_clk), .reset_n(reset_n), .want_special(wsp),
        .dev_out(pout), .dev_oe_n(poe_n), .debug_wire_pin(pin), .req(req));
    bdr_regs u_bdr_regs (
        .core_clk(core_clk), .reset_n(reset_n), .debug_wire_pin(pin),
        .debug_wire_out(pout), .debug_wire_oe_n(poe_n), .special_mode(smode),
        .serial_enable(ser), .high_tag_pin(ht), .low_tag_pin(lt), .low_strobe_en(lse),
        .external_bus_clock(ebc), .tag_high(th), .tag_low(tl), .req(req), .rdata(rdata),
        .rvalid(rvalid), .evt(evt), .fw_set_enable(fse), .secured(sec), .erased(ers),
        .erase_done(edn), .reg_base(base), .pll_select_signal(pll), .debug_active(act),
        .fw_table_mapped(ftm), .use_alt_clock(alt), .clock_settling(settle),
        .status_view(sv));

    // ==========
    // clock, watchdog, helpers
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end
    task automatic tick(input int k = 1);
        repeat (k) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
        check_count++;
        if (s !== x) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, x, s);
        end
    endtask
    function automatic logic [7:0] st_exp();
        return 8'(m_en * 128 + m_act * 64 + m_tag * 32 + m_sdv * 16 + m_trc * 8 + m_clk * 4
            + 2 * int'((sec && ers) || m_uns != 0));
    endfunction
    task automatic rd(input logic [15:0] a, input logic [7:0] x);
        u_bdr_host.put(1'b0, 1'b0, 1'b0, a, 8'h00);
        chk("rvalid", 8'(rvalid), 8'h01);
        chk("rdata", rdata, x);
    endtask
    task automatic wst(input logic [7:0] v, input logic fw, input logic sfw);
        u_bdr_host.put(!fw, fw, sfw, bdr_pkg::ADDR_STATUS, v);
        m_en = v[7];
        m_tag = v[5];
        m_sdv = v[4];
        m_trc = v[3];
        m_clk = v[2];
        if (sfw) m_uns = v[1];
    endtask
    // model: data phase beats new command, entry clear beats tag-and-go, exit store clears last
    task automatic ev(input logic [6:0] x);
        tick();
        evt = bdr_pkg::bdr_evt_t'(x);
        tick();
        evt = '0;
        if (x[6]) begin
            m_sdv = 0;
            m_trc = int'(x[5:4] == 2'b01);
            if (x[5:4] == 2'b10) m_tag = 1;
        end
        if (x[3]) m_sdv = 1;
        if (x[2] && m_en != 0) begin
            m_act = 1;
            m_tag = 0;
        end
        if (x[1]) begin
            m_act = 0;
            m_sdv = 0;
        end
        if (x[0]) m_uns = 0;
    endtask
    // long half period leaves room for pin synchronisers
    task automatic bus_clk(input int k);
        nh = 0;
        nl = 0;
        repeat (2 * k) begin
            ebc = ~ebc;
            repeat (6) begin
                tick();
                nh += int'(th === 1'b1);
                nl += int'(tl === 1'b1);
            end
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========
    // scenarios
    initial begin
        void'($urandom(74));
        tick(6);
        reset_n = 1'b1;
        tick(3);
        chk("mode", 8'(smode), 8'h01);
        chk("serial", 8'(ser), 8'h01);
        rd(bdr_pkg::ADDR_STATUS, st_exp());
        rd(bdr_pkg::ADDR_CCR_HOLD, bdr_pkg::CCR_SPECIAL);
        for (int i = 0; i < 6; i++) begin
            d = 8'($urandom);
            base = 16'($urandom);
            u_bdr_host.put(1'b1, 1'b0, 1'b0, bdr_pkg::ADDR_CCR_HOLD, d);
            u_bdr_host.put(1'b1, 1'b0, 1'b0, bdr_pkg::ADDR_BASE_SHDW, ~d);
            rd(bdr_pkg::ADDR_CCR_HOLD, d);
            rd(bdr_pkg::ADDR_BASE_SHDW, {1'b0, base[14:11], 3'b000});
        end
        foreach (rsv[i]) begin
            u_bdr_host.put(1'b1, 1'b0, 1'b0, rsv[i], 8'hff);
            rd(rsv[i], bdr_pkg::READ_RESERVED);
        end
        rd(bdr_pkg::ADDR_STATUS, st_exp());
        wst(8'hdf, 1'b0, 1'b0);
        chk("status", sv, 8'h9c);
        for (int i = 0; i < 4; i++) begin
            pll = i[0];
            wst({1'b1, 4'h0, i[1], 2'b00}, i[0], 1'b0);
            chk("alt", 8'(alt), 8'(!i[1] && i[0]));
        end
        chk("settling", 8'(settle), 8'h01);
        tick(160);
        chk("settled", 8'(settle), 8'h00);
        for (int i = 0; i < 30; i++) begin
            e = 7'($urandom) & 7'b1011111;
            if (e[2] || e[3]) e[1] = 1'b0;
            if (i % 3 == 0) wst(8'($urandom) & 8'h9e, i[0], i[1] & ~i[0]);
            ev(e);
            rd(bdr_pkg::ADDR_STATUS, st_exp());
            chk("active", 8'(act), 8'(m_act));
            chk("table", 8'(ftm), 8'(m_act));
        end
        wst(8'h00, 1'b0, 1'b0);
        sec = 1'b1;
        ers = 1'b1;
        fse = 1'b1;
        tick(2);
        rd(bdr_pkg::ADDR_STATUS, st_exp());
        edn = 1'b1;
        m_en = 1;
        tick(2);
        rd(bdr_pkg::ADDR_STATUS, st_exp());
        fse = 1'b0;
        ht = 1'b0;
        lt = 1'b0;
        lse = 1'b1;
        bus_clk(3);
        chk("tag idle", 8'(nh + nl), 8'h00);
        ev(7'b1100000);
        chk("tagging_enable_bit", 8'(sv[5]), 8'h01);
        n = 0;
        while (ser === 1'b1 && n < 40) begin
            tick();
            n++;
        end
        chk("tag delay", 8'(n >= 14 && n <= 18), 8'h01);
        lt = 1'b1;
        bus_clk(4);
        chk("tag high", 8'(nh), 8'h04);
        chk("tag low", 8'(nl), 8'h00);
        ht = 1'b1;
        lt = 1'b0;
        bus_clk(4);
        chk("tag high", 8'(nh), 8'h00);
        chk("tag low", 8'(nl), 8'h04);
        // second reset with the pin strapped high: normal mode
        reset_n = 1'b0;
        wsp = 1'b0;
        tick(6);
        reset_n = 1'b1;
        tick(3);
        chk("mode", 8'(smode), 8'h00);
        chk("released", 8'(poe_n), 8'h01);
        rd(bdr_pkg::ADDR_CCR_HOLD, bdr_pkg::CCR_RESET);
        results();
    end
endmodule
